// *** src/fcs_buscycle.sv ***
// One flash bus cycle: drives chip select, write or output strobe, address
// and data lines with fixed setup and pulse widths.
// Assumes the flash pins are sampled by the device on strobe edges only.
`timescale 1ns/10ps
module fcs_buscycle
    import fcs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Request side
    input wire logic start,
    input wire fcs_cyc_t kind,
    input wire logic [18:0] addr,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata,
    // Flash pins
    output logic [18:0] fl_addr,
    output logic fl_cs_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    input wire logic [7:0] fl_dq_in,
    output logic [7:0] fl_dq_out,
    output logic fl_dq_oe
);
    typedef struct packed {
        logic [1:0] phase;
        logic [7:0] cnt;
        fcs_cyc_t kind;
        logic [18:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done;
    } fcs_bc_t;
    fcs_bc_t st;
    fcs_bc_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Phase 0 idle, 1 address setup, 2 strobe low, 3 hold after rising edge
    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.phase)
            2'd0:
            begin
                if (start)
                begin
                    next_st.phase = 2'd1;
                    next_st.kind = kind;
                    next_st.addr = addr;
                    next_st.wdata = wdata;
                    next_st.cnt = 8'(fcs_setup_cyc);
                end
            end
            2'd1:
            begin
                next_st.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h01)
                begin
                    next_st.phase = 2'd2;
                    next_st.cnt = 8'(fcs_strobe_cyc);
                end
            end
            2'd2:
            begin
                next_st.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h01)
                begin
                    // Read data sampled while output strobe is still low
                    next_st.rdata = fl_dq_in;
                    next_st.phase = 2'd3;
                end
            end
            default:
            begin
                next_st.phase = 2'd0;
                next_st.kind = fcs_cyc_idle;
                next_st.done = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (srst)
            st <= '0;
        else
            st <= next_st;
    end

    // Address stands through the whole cycle so the earlier falling edge
    // and the later rising edge both see stable address and data
    assign fl_addr = st.addr;
    assign fl_cs_n = !(st.phase == 2'd2);
    assign fl_we_n = !(st.phase == 2'd2 && st.kind == fcs_cyc_write);
    assign fl_oe_n = !(st.phase == 2'd2 && st.kind == fcs_cyc_read);
    assign fl_dq_out = st.wdata;
    assign fl_dq_oe = (st.phase != 2'd0) && (st.kind == fcs_cyc_write);
    assign done = st.done;
    assign rdata = st.rdata;
endmodule : fcs_buscycle

// *** src/fcs_ctrl.sv ***
// Host-side flash command controller: software writes address, data and an
// opcode over AHB-Lite; the block issues the unlock and command bus cycles,
// then, for program and erase only, polls toggle_bit_one (bit 6) and bit 5 until the operation ends.
// Assumes one AHB-Lite master, single word transfers, and a flash behind.
//
// What this block does
// - Reset byte f0 returns flash to array read
// - Autoselect: two unlock writes, then 90
// - Program: two unlocks, a0, then target byte
// - Erase: six writes, 10 chip or 30 sector
// - All command cycles are writes except reads
// - Suspend byte b0 written only while idle, never mid-erase
// - Byte 30 resumes a suspended sector erase
// - Poll at program address or erased sector
// - Full byte taken from a later read
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module fcs_ctrl
    import fcs_pkg::*;
#(
    parameter int addr_width = 19
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Flash pins
    output logic [addr_width-1:0] fl_addr,
    output logic fl_cs_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    input wire logic [7:0] fl_dq_in,
    output logic [7:0] fl_dq_out,
    output logic fl_dq_oe
);
    typedef enum logic [2:0] {
        fcs_s_idle = 3'b000,
        fcs_s_issue = 3'b001,
        fcs_s_wait = 3'b010,
        fcs_s_poll = 3'b011,
        fcs_s_poll_wait = 3'b100
    } fcs_state_t;

    typedef struct packed {
        fcs_state_t state;
        logic [18:0] addr;
        logic [7:0] data;
        logic [3:0] op;
        logic [2:0] step;
        logic [2:0] nsteps;
        logic polling;
        logic busy;
        logic done;
        logic fail;
        logic toggled;
        logic have_prev;
        logic [7:0] prev;
        logic [7:0] rdata;
        logic wr_pend;
        logic [7:0] wr_off;
    } fcs_ctl_t;
    fcs_ctl_t st;
    fcs_ctl_t next_st;

    logic bc_start;
    fcs_cyc_t bc_kind;
    logic [18:0] bc_addr;
    logic [7:0] bc_wdata;
    logic bc_done;
    logic [7:0] bc_rdata;

    // Address and data of step n of the current command sequence
    function automatic logic [26:0] fcs_seq(input logic [3:0] op, input logic [2:0] n,
                                            input logic [18:0] a, input logic [7:0] d);
        logic [7:0] third;
        logic [7:0] last;
        third = (op == fcs_op_program) ? fcs_cmd_program :
                (op == fcs_op_autosel) ? fcs_cmd_autosel : fcs_cmd_erase_setup;
        last = (op == fcs_op_chip_erase) ? fcs_cmd_chip_erase : fcs_cmd_sector_erase;
        case (n)
            3'd0: fcs_seq = {fcs_addr_unlock1, fcs_dat_unlock1};
            3'd1: fcs_seq = {fcs_addr_unlock2, fcs_dat_unlock2};
            3'd2: fcs_seq = {fcs_addr_unlock1, third};
            3'd3: fcs_seq = (op == fcs_op_program) ? {a, d} : {fcs_addr_unlock1, fcs_dat_unlock1};
            3'd4: fcs_seq = {fcs_addr_unlock2, fcs_dat_unlock2};
            default: fcs_seq = (op == fcs_op_chip_erase) ? {fcs_addr_unlock1, last}
                                                         : {a, last};
        endcase
    endfunction : fcs_seq

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and AHB register writes
    always_comb
    begin
        next_st = st;
        bc_start = 1'b0;
        bc_kind = fcs_cyc_write;
        bc_addr = st.addr;
        bc_wdata = st.data;
        // AHB write data phase lands here
        if (st.wr_pend)
        begin
            next_st.wr_pend = 1'b0;
            if (st.wr_off == fcs_reg_addr)
                next_st.addr = hwdata[18:0];
            else if (st.wr_off == fcs_reg_data)
                next_st.data = hwdata[7:0];
            else if (st.wr_off == fcs_reg_cmd && st.state == fcs_s_idle)
            begin
                next_st.op = hwdata[3:0];
                next_st.step = 3'd0;
                next_st.busy = 1'b1;
                next_st.done = 1'b0;
                next_st.fail = 1'b0;
                next_st.toggled = 1'b0;
                next_st.have_prev = 1'b0;
                next_st.state = fcs_s_issue;
                case (hwdata[3:0])
                    fcs_op_program: next_st.nsteps = 3'd4;
                    fcs_op_chip_erase, fcs_op_sector_erase: next_st.nsteps = 3'd6;
                    fcs_op_autosel: next_st.nsteps = 3'd3;
                    default: next_st.nsteps = 3'd1;
                endcase
                // Polling only for program and erase kinds
                next_st.polling = (hwdata[3:0] == fcs_op_program) ||
                                  (hwdata[3:0] == fcs_op_chip_erase) ||
                                  (hwdata[3:0] == fcs_op_sector_erase);
            end
        end
        case (st.state)
            fcs_s_issue:
            begin
                bc_start = 1'b1;
                next_st.state = fcs_s_wait;
                // Every sequence step is a write except plain reads
                if (st.op == fcs_op_read)
                    bc_kind = fcs_cyc_read;
                else if (st.op == fcs_op_reset)
                    bc_wdata = fcs_cmd_reset;
                else if (st.op == fcs_op_suspend)
                    bc_wdata = fcs_cmd_suspend;
                else if (st.op == fcs_op_resume)
                    bc_wdata = fcs_cmd_resume;
                else if (st.op != fcs_op_write_raw)
                    {bc_addr, bc_wdata} = fcs_seq(st.op, st.step, st.addr, st.data);
            end
            fcs_s_wait:
            begin
                if (bc_done)
                begin
                    next_st.rdata = bc_rdata;
                    next_st.step = st.step + 3'd1;
                    if (st.step + 3'd1 != st.nsteps)
                        next_st.state = fcs_s_issue;
                    else if (st.polling)
                        next_st.state = fcs_s_poll;
                    else
                    begin
                        next_st.state = fcs_s_idle;
                        next_st.busy = 1'b0;
                        next_st.done = 1'b1;
                    end
                end
            end
            fcs_s_poll:
            begin
                // Poll at the program address or in the erased sector
                bc_start = 1'b1;
                bc_kind = fcs_cyc_read;
                bc_addr = st.addr;
                next_st.state = fcs_s_poll_wait;
            end
            fcs_s_poll_wait:
            begin
                if (bc_done)
                begin
                    next_st.prev = bc_rdata;
                    next_st.have_prev = 1'b1;
                    next_st.state = fcs_s_poll;
                    // Toggle bit steady across two reads means finished
                    if (st.have_prev && (bc_rdata[6] == st.prev[6]))
                    begin
                        next_st.state = fcs_s_idle;
                        next_st.busy = 1'b0;
                        next_st.done = 1'b1;
                        // Final byte is this later read, not the first change
                        next_st.rdata = bc_rdata;
                    end
                    else if (st.have_prev)
                    begin
                        next_st.toggled = 1'b1;
                        if (st.prev[5] && bc_rdata[5])
                        begin
                            // Timing limit with toggle still running: fail
                            next_st.fail = 1'b1;
                            next_st.op = fcs_op_reset;
                            next_st.nsteps = 3'd1;
                            next_st.step = 3'd0;
                            next_st.polling = 1'b0;
                            next_st.state = fcs_s_issue;
                        end
                    end
                end
            end
            default:
            begin
            end
        endcase
        // Capture AHB write address phase
        if (hsel && hready && htrans[1] && hwrite)
        begin
            next_st.wr_pend = 1'b1;
            next_st.wr_off = haddr[7:0];
        end
    end
    // State register
    always_ff @(posedge mclk)
    begin
        if (srst)
            st <= '0;
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB read data, registered; zero-wait, always OKAY
    logic [31:0] rd_word;
    logic [31:0] next_rd;
    always_comb
    begin
        next_rd = 32'h0000_0000;
        if (haddr[7:0] == fcs_reg_addr)
            next_rd = {13'h0000, st.addr};
        else if (haddr[7:0] == fcs_reg_data)
            next_rd = {24'h000000, st.data};
        else if (haddr[7:0] == fcs_reg_cmd)
            next_rd = {28'h0000000, st.op};
        else if (haddr[7:0] == fcs_reg_status)
            next_rd = {28'h0000000, st.toggled, st.fail, st.done, st.busy};
        else if (haddr[7:0] == fcs_reg_rdata)
            next_rd = {24'h000000, st.rdata};
    end
    // Read word registered at the address phase
    always_ff @(posedge mclk)
    begin
        if (srst)
            rd_word <= 32'h0000_0000;
        else if (hsel && hready && htrans[1] && !hwrite)
            rd_word <= next_rd;
    end
    assign hrdata = rd_word;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // One flash bus cycle at a time
    fcs_buscycle u_bus (
        .mclk(mclk),
        .srst(srst),
        .start(bc_start),
        .kind(bc_kind),
        .addr(bc_addr),
        .wdata(bc_wdata),
        .done(bc_done),
        .rdata(bc_rdata),
        .fl_addr(fl_addr),
        .fl_cs_n(fl_cs_n),
        .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n),
        .fl_dq_in(fl_dq_in),
        .fl_dq_out(fl_dq_out),
        .fl_dq_oe(fl_dq_oe)
    );
endmodule : fcs_ctrl

// *** src/fcs_pkg.sv ***
// Package for the flash command controller: command bytes, unlock addresses,
// register map of the controller's own AHB-Lite slave, and bus timing counts.
// Assumes a byte-wide asynchronous flash on the far side of the pins.
package fcs_pkg;
    // Flash unlock addresses and command bytes
    localparam logic [18:0] fcs_addr_unlock1 = 19'h00555;
    localparam logic [18:0] fcs_addr_unlock2 = 19'h002aa;
    localparam logic [7:0] fcs_dat_unlock1 = 8'haa;
    localparam logic [7:0] fcs_dat_unlock2 = 8'h55;
    localparam logic [7:0] fcs_cmd_reset = 8'hf0;
    localparam logic [7:0] fcs_cmd_autosel = 8'h90;
    localparam logic [7:0] fcs_cmd_program = 8'ha0;
    localparam logic [7:0] fcs_cmd_erase_setup = 8'h80;
    localparam logic [7:0] fcs_cmd_chip_erase = 8'h10;
    localparam logic [7:0] fcs_cmd_sector_erase = 8'h30;
    localparam logic [7:0] fcs_cmd_suspend = 8'hb0;
    localparam logic [7:0] fcs_cmd_resume = 8'h30;
    // Autoselect read offsets
    localparam logic [18:0] fcs_as_maker = 19'h00000;
    localparam logic [18:0] fcs_as_part = 19'h00001;
    localparam logic [18:0] fcs_as_protect = 19'h00002;
    // Sector field position inside the byte address
    localparam int fcs_sector_lsb = 16;
    // Register byte offsets
    localparam logic [7:0] fcs_reg_addr = 8'h00;
    localparam logic [7:0] fcs_reg_data = 8'h04;
    localparam logic [7:0] fcs_reg_cmd = 8'h08;
    localparam logic [7:0] fcs_reg_status = 8'h0c;
    localparam logic [7:0] fcs_reg_rdata = 8'h10;
    // Command register opcodes
    localparam logic [3:0] fcs_op_read = 4'h1;
    localparam logic [3:0] fcs_op_reset = 4'h2;
    localparam logic [3:0] fcs_op_autosel = 4'h3;
    localparam logic [3:0] fcs_op_program = 4'h4;
    localparam logic [3:0] fcs_op_chip_erase = 4'h5;
    localparam logic [3:0] fcs_op_sector_erase = 4'h6;
    localparam logic [3:0] fcs_op_suspend = 4'h7;
    localparam logic [3:0] fcs_op_resume = 4'h8;
    localparam logic [3:0] fcs_op_write_raw = 4'h9;
    // Strobe timing, in ns and in cycles of the 5 ns clock
    localparam int fcs_clk_ns = 5;
    localparam int fcs_strobe_ns = 60;
    localparam int fcs_setup_ns = 20;
    localparam int fcs_strobe_cyc = (fcs_strobe_ns + fcs_clk_ns - 1) / fcs_clk_ns;
    localparam int fcs_setup_cyc = (fcs_setup_ns + fcs_clk_ns - 1) / fcs_clk_ns;
    // Status bits of the status register
    localparam int fcs_st_busy = 0;
    localparam int fcs_st_done = 1;
    localparam int fcs_st_fail = 2;
    localparam int fcs_st_toggle = 3;
    // Flash bus cycle kinds
    typedef enum logic [1:0] {
        fcs_cyc_idle = 2'b00,
        fcs_cyc_write = 2'b01,
        fcs_cyc_read = 2'b10
    } fcs_cyc_t;
endpackage : fcs_pkg

// *** tb/fcs_ctrl_props.sv ***
// Checker for the flash command controller: flash pin timing and strobe rules.
// Assumes the package strobe count and one clock domain.
`timescale 1ns/10ps
module fcs_ctrl_props
    import fcs_pkg::*;
#(
    parameter int addr_width = 19
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Flash pins
    input wire logic [addr_width-1:0] fl_addr,
    input wire logic fl_cs_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic [7:0] fl_dq_out,
    input wire logic fl_dq_oe
);
    logic [7:0] low_cnt;
    logic strobe_low;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    assign strobe_low = !fl_we_n || !fl_oe_n;
    // Counts pulse length, so a short pulse cannot pass as a long one
    always_ff @(posedge mclk)
    begin
        if (srst || !strobe_low)
            low_cnt <= 8'h00;
        else
            low_cnt <= low_cnt + 8'h01;
    end
    ////////////////////////////////////////
    property p_len;
        $fell(strobe_low) |-> int'(low_cnt) == fcs_strobe_cyc;
    endproperty
    a_len: assert property (p_len) else $error("strobe length wrong");
    property p_gap;
        $fell(strobe_low) |-> (!strobe_low)[*5];
    endproperty
    a_gap: assert property (p_gap) else $error("strobe gap too short");
    property p_one;
        !(!fl_we_n && !fl_oe_n);
    endproperty
    a_one: assert property (p_one) else $error("both strobes low");
    property p_cs;
        strobe_low |-> !fl_cs_n;
    endproperty
    a_cs: assert property (p_cs) else $error("strobe without select");
    property p_hold;
        strobe_low && $past(strobe_low) |-> $stable(fl_addr) && $stable(fl_dq_out);
    endproperty
    a_hold: assert property (p_hold) else $error("bus moved in pulse");
    property p_edges;
        $rose(strobe_low) || $fell(strobe_low) |-> $stable(fl_addr) && $stable(fl_dq_out);
    endproperty
    a_edges: assert property (p_edges) else $error("bus moved at edge");
    property p_drive;
        !fl_we_n |-> fl_dq_oe;
    endproperty
    a_drive: assert property (p_drive) else $error("write not driven");
    property p_float;
        !fl_oe_n |-> !fl_dq_oe;
    endproperty
    a_float: assert property (p_float) else $error("driving in read");
endmodule : fcs_ctrl_props
bind fcs_ctrl fcs_ctrl_props #(.addr_width(addr_width)) i_props (.mclk(mclk), .srst(srst),
    .fl_addr(fl_addr), .fl_cs_n(fl_cs_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe));

// *** tb/fcs_flash_model.sv ***
// Behavioural byte-wide flash: command decode, program, erase, status bits.
// Assumes strobes from the controller; no clock of its own.
`timescale 1ns/10ps
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter logic [7:0] prot = 8'h04,
    parameter logic [7:0] maker_code = 8'h5a, // Arbitrary value
    parameter logic [7:0] part_code = 8'hc3 // Arbitrary value
)
(
    // Flash pins
    input wire logic [18:0] fl_addr,
    input wire logic fl_cs_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic [7:0] fl_dq_out,
    output logic [7:0] fl_dq_in,
    // Fault control
    input wire logic stuck
);
    logic [7:0] mem [0:524287];
    logic [7:0] v = 8'h00;
    logic [7:0] pb = 8'h00;
    logic [18:0] la;
    logic [2:0] es;
    int step = 0;
    bit asel, susp, ers, prg, tog, chip;
    realtime t_end = 0, rem = 0;
    wire wr_n = fl_we_n | fl_cs_n;
    wire rd_n = fl_oe_n | fl_cs_n;
    // Released bus shows the inverse, so a stale value never reads right
    assign fl_dq_in = rd_n ? ~v : v;
    initial for (int k = 0; k < 524288; k++) mem[k] = 8'hff;
    ////////////////////////////////////////
    // Upper address bits take no part in unlock cycles
    function automatic int nxt(int s, logic [10:0] a, logic [7:0] d);
        if ((s == 0 || s == 4) && a == 11'h555 && d == fcs_dat_unlock1) return s + 1;
        if ((s == 1 || s == 5) && a == 11'h2aa && d == fcs_dat_unlock2) return s + 1;
        if (s == 2 && a == 11'h555 && d == fcs_cmd_program) return 3;
        if (s == 2 && a == 11'h555 && d == fcs_cmd_erase_setup && !susp) return 4;
        return 0;
    endfunction : nxt
    always @(negedge wr_n) la = fl_addr;
    // Data and command take effect on the rising edge
    always @(posedge wr_n)
    begin
        if ($realtime < t_end)
        begin
            if (ers && !prg && !chip && fl_dq_out == fcs_cmd_suspend)
            begin
                rem = t_end - $realtime;
                t_end = 0;
                susp = 1;
            end
            else if (stuck && fl_dq_out == fcs_cmd_reset)
                t_end = 0;
        end
        else if (step == 0 && susp && fl_dq_out == fcs_cmd_resume)
        begin
            t_end = $realtime + rem;
            susp = 0;
        end
        else if (step != 3 && fl_dq_out == fcs_cmd_reset)
            asel = 0;
        else if (step == 3)
        begin
            pb = fl_dq_out;
            prg = 1;
            if (!prot[la[18:16]])
                mem[la] = mem[la] & fl_dq_out;
            t_end = $realtime + (stuck ? 1e9 : prot[la[18:16]] ? 2000 : 3000);
        end
        else if (step == 6 && fl_dq_out inside {fcs_cmd_chip_erase, fcs_cmd_sector_erase})
        begin
            chip = fl_dq_out == fcs_cmd_chip_erase;
            es = la[18:16];
            ers = 1;
            prg = 0;
            for (int k = 0; k < 524288; k++)
                if (!prot[k[18:16]] && (chip || k[18:16] == es)) mem[k] = 8'hff;
            t_end = $realtime + ((chip ? &prot : prot[es]) ? 100000 : 20000);
        end
        if (step == 2 && fl_dq_out == fcs_cmd_autosel && la[10:0] == 11'h555)
            asel = 1;
        step = ($realtime < t_end) ? 0 : nxt(step, la[10:0], fl_dq_out);
    end
    // Status while busy; bit 6 flips on every read at any address
    always @(negedge rd_n)
    begin
        if ($realtime < t_end)
        begin
            tog = !tog;
            v = {(ers && !prg) ? 1'b0 : ~pb[7], tog, stuck, 5'h00};
        end
        else if (asel)
            v = fl_addr[7:0] == 8'h00 ? maker_code : fl_addr[7:0] == 8'h01 ? part_code
                : {7'h00, prot[fl_addr[18:16]]};
        else if (susp && fl_addr[18:16] == es)
            v = {1'b1, tog, 6'h00};
        else
            v = mem[fl_addr];
    end
endmodule : fcs_flash_model

// *** tb/testbench.sv ***
// Self-checking bench for the flash controller over AHB-Lite.
// Assumes the flash model behind the pins and a 200 MHz clock.
`timescale 1ns/10ps
module testbench
    import fcs_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic stuck = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hready, hreadyout, hresp, fl_cs_n, fl_we_n, fl_oe_n, fl_dq_oe;
    logic [18:0] fl_addr;
    logic [7:0] fl_dq_in, fl_dq_out;
    int errors = 0, checked = 0;
    assign hready = hreadyout;
    initial forever #2.5 mclk = ~mclk;
    fcs_ctrl #(.addr_width(19)) i_dut (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fl_addr(fl_addr),
        .fl_cs_n(fl_cs_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_in(fl_dq_in),
        .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe));
    fcs_flash_model i_flash (.fl_addr(fl_addr), .fl_cs_n(fl_cs_n), .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n), .fl_dq_out(fl_dq_out), .fl_dq_in(fl_dq_in), .stuck(stuck));
    ////////////////////////////////////////
    task automatic test_done();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    // Every wait is bounded; a hang ends the run as a mismatch
    task automatic give_up(input bit hit);
        if (hit)
        begin
            errors++;
            $display("unexpected at %0t: wait ran out", $time);
            test_done();
        end
    endtask : give_up
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hready !== 1'b1 && n < 40);
        give_up(n >= 40);
    endtask : wait_ready
    // One single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : ahb
    task automatic run_op(input logic [3:0] op, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        ahb(1'b1, fcs_reg_addr, {13'h0000, a});
        ahb(1'b1, fcs_reg_data, {24'h000000, d});
        ahb(1'b1, fcs_reg_cmd, {28'h0000000, op});
        do
        begin
            ahb(1'b0, fcs_reg_status, 32'h0);
            n++;
        end
        while (q[fcs_st_busy] !== 1'b0 && n < 12000);
        give_up(n >= 12000);
    endtask : run_op
    task automatic chk_status(input logic [3:0] st);
        ahb(1'b0, fcs_reg_status, 32'h0);
        check({28'h0, q[3:0]}, {28'h0, st}, "status");
    endtask : chk_status
    task automatic rd_at(input logic [18:0] a, input logic [7:0] exp);
        run_op(fcs_op_read, a, 8'h00);
        ahb(1'b0, fcs_reg_rdata, 32'h0);
        check(q, {24'h0, exp}, "read data");
    endtask : rd_at
    ////////////////////////////////////////
    task automatic t_idle();
        chk_status(4'b0000);
        check({31'h0, hresp}, 32'h0, "response");
        ahb(1'b0, 8'h20, 32'h0);
        check(q, 32'h0, "unmapped read");
    endtask : t_idle
    task automatic t_program();
        run_op(fcs_op_program, 19'h12345, 8'h3c);
        chk_status(4'b1010);
        rd_at(19'h12345, 8'h3c);
        run_op(fcs_op_program, 19'h7ffff, 8'h81);
        rd_at(19'h7ffff, 8'h81);
        run_op(fcs_op_program, 19'h20010, 8'h00);
        chk_status(4'b1010);
        rd_at(19'h20010, 8'hff);
    endtask : t_program
    task automatic t_autosel();
        run_op(fcs_op_autosel, 19'h00000, 8'h00);
        rd_at(19'h00000, 8'h5a);
        rd_at(19'h00001, 8'hc3);
        rd_at(19'h20002, 8'h01);
        rd_at(19'h10002, 8'h00);
        run_op(fcs_op_reset, 19'h00000, 8'h00);
        rd_at(19'h12345, 8'h3c);
    endtask : t_autosel
    // Suspend, resume and a stray write while idle change nothing
    task automatic t_ignored();
        run_op(fcs_op_suspend, 19'h12345, 8'h00);
        run_op(fcs_op_resume, 19'h12345, 8'h00);
        run_op(fcs_op_write_raw, 19'h00555, 8'h12);
        rd_at(19'h12345, 8'h3c);
    endtask : t_ignored
    task automatic t_fail();
        stuck <= 1'b1;
        run_op(fcs_op_program, 19'h12345, 8'h3c);
        check({31'h0, q[fcs_st_fail]}, 32'h1, "fail flag");
        stuck <= 1'b0;
        rd_at(19'h12345, 8'h3c);
    endtask : t_fail
    task automatic t_erase();
        run_op(fcs_op_program, 19'h30000, 8'h00);
        run_op(fcs_op_sector_erase, 19'h3abcd, 8'h00);
        chk_status(4'b1010);
        rd_at(19'h30000, 8'hff);
        rd_at(19'h12345, 8'h3c);
        run_op(fcs_op_sector_erase, 19'h20000, 8'h00);
        chk_status(4'b1010);
        run_op(fcs_op_chip_erase, 19'h00555, 8'h00);
        rd_at(19'h12345, 8'hff);
        rd_at(19'h7ffff, 8'hff);
    endtask : t_erase
    ////////////////////////////////////////
    // Reset for 20 cycles, then the scenarios in turn
    initial
    begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        t_idle();
        t_program();
        t_autosel();
        t_ignored();
        t_fail();
        t_erase();
        test_done();
    end
endmodule : testbench
